// ### src/event_irq_pkg.sv
`default_nettype none
package event_irq_pkg;
    localparam int BUS_ADDR_W = 4;
    localparam logic [3:0] ENABLE_OFFSET = 4'h0;
    localparam logic [3:0] FLAG_OFFSET = 4'h4;
    // field positions
    localparam int OUT_ENABLE_BIT = 15;
    localparam int READY_BIT = 4;
    localparam int POR_BIT = 2;
    localparam int ECC2_BIT = 1;
    localparam int ECC1_BIT = 0;
    // reset values
    localparam logic [15:0] ENABLE_RESET = 16'hFFFF;
    localparam logic [15:0] FLAG_HW_RESET = 16'hFFFF;
    localparam logic [15:0] FLAG_POR_RESET = 16'hFFFB;
    // bits that software can change
    localparam logic [15:0] ENABLE_WRITABLE = 16'h8013;
    localparam logic [15:0] FLAG_WRITABLE = 16'h0017;
    localparam logic [15:0] SOURCE_MASK = 16'h0013;

    typedef struct packed {
        logic ready;
        logic ecc2;
        logic ecc1;
    } event_pulse_type;

    typedef struct packed {
        logic read;
        logic write;
        logic [3:0] byteenable;
        logic [31:0] writedata;
        logic [BUS_ADDR_W-1:0] address;
    } bus_req_type;
endpackage
`default_nettype wire

// ### src/event_pulse_capture.sv
`default_nettype none
module event_pulse_capture (
    input wire logic clk, // system clock
    input wire logic rst_b, // power-on reset, active low
    input wire logic busy, // internal busy level
    input wire logic ecc1_detect, // one-bit ECC pulse
    input wire logic ecc2_detect, // two-bit ECC pulse
    output event_irq_pkg::event_pulse_type events // one-cycle event pulses
);
    logic busy_prev;

    // previous busy level; resets low so no false edge at release
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            busy_prev <= 1'b0;
        else
            busy_prev <= busy;
    end

    // falling busy means the device became ready
    assign events.ready = busy_prev & ~busy;
    assign events.ecc2 = ecc2_detect;
    assign events.ecc1 = ecc1_detect;

    chk_ready_edge: assert property (@(posedge clk) disable iff (!rst_b)
        (busy ##1 !busy) |-> events.ready)
        else $error("busy fall gave no ready pulse");
endmodule
`default_nettype wire

// ### src/avmm_handshake.sv
`default_nettype none
module avmm_handshake (
    input wire logic clk, // system clock
    input wire logic rst_b, // power-on reset, active low
    input wire logic request, // read or write asserted
    output logic waitrequest, // Avalon waitrequest
    output logic capture, // first cycle of a request
    output logic take // cycle in which the request completes
);
    // one wait cycle lets read data be registered before the accept edge
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            waitrequest <= 1'b1;
        else if (request && waitrequest)
            waitrequest <= 1'b0;
        else
            waitrequest <= 1'b1;
    end

    assign capture = request & waitrequest;
    assign take = request & ~waitrequest;

    chk_wait_bound: assert property (@(posedge clk) disable iff (!rst_b)
        capture |=> !waitrequest)
        else $error("waitrequest not released after one cycle");
endmodule
`default_nettype wire

// ### src/flash_event_interrupt_logic.sv
`default_nettype none
module flash_event_interrupt_logic (
    input wire logic clk, // system clock, 20 MHz
    input wire logic rst_b, // power-on reset, async, active low
    input wire logic hw_reset_b, // hardware reset pulse, sync, active low
    input wire logic busy, // internal busy indication
    input wire logic ecc1_detect, // one-bit ECC detection pulse
    input wire logic ecc2_detect, // two-bit ECC detection pulse
    input wire logic [event_irq_pkg::BUS_ADDR_W-1:0] address, // byte address
    input wire logic read, // Avalon read
    input wire logic write, // Avalon write
    input wire logic [31:0] writedata, // Avalon write data
    input wire logic [3:0] byteenable, // Avalon byte enables
    output logic [31:0] readdata, // Avalon read data
    output logic waitrequest, // Avalon waitrequest
    output logic alert_out, // alert pin drive value, always low
    output logic alert_oe // alert pin enable, high while pulling low
);
    event_irq_pkg::event_pulse_type events;
    event_irq_pkg::bus_req_type req;
    logic [15:0] enable_reg;
    logic [15:0] flag_reg;
    logic [15:0] next_enable;
    logic [15:0] next_flags;
    logic next_alert_oe;
    logic capture;
    logic take;
    logic wait_int;

    // merge the two low byte lanes of a write into a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wdata,
                                            input logic [3:0] be);
        logic [15:0] res;
        res = old;
        if (be[0])
            res[7:0] = wdata[7:0];
        if (be[1])
            res[15:8] = wdata[15:8];
        return res;
    endfunction

    // ones written into the low lanes; other bits read as zero
    function automatic logic [15:0] ones16(input logic [31:0] wdata,
                                           input logic [3:0] be);
        return merge16(16'h0000, wdata, be);
    endfunction

    assign req.read = read;
    assign req.write = write;
    assign req.byteenable = byteenable;
    assign req.writedata = writedata;
    assign req.address = address;

    event_pulse_capture u_capture (
        .clk(clk),
        .rst_b(rst_b),
        .busy(busy),
        .ecc1_detect(ecc1_detect),
        .ecc2_detect(ecc2_detect),
        .events(events)
    );

    avmm_handshake u_bus (
        .clk(clk),
        .rst_b(rst_b),
        .request(req.read | req.write),
        .waitrequest(wait_int),
        .capture(capture),
        .take(take)
    );

    assign waitrequest = wait_int;

    // address decode; reads also decode in the capture cycle
    wire hit_enable = (req.address == event_irq_pkg::ENABLE_OFFSET);
    wire hit_flag = (req.address == event_irq_pkg::FLAG_OFFSET);
    wire enable_write = take & req.write & hit_enable;
    wire flag_write = take & req.write & hit_flag;
    wire [15:0] wr_ones = ones16(req.writedata, req.byteenable);

    // event pulses mapped to flag positions, gated by their enables
    wire [15:0] event_vec = {11'h000, events.ready, 2'b00,
                             events.ecc2, events.ecc1};
    wire [15:0] event_low = event_vec & ~enable_reg & event_irq_pkg::SOURCE_MASK;

    // bits returned to 1 by software
    wire out_disable_wr = enable_write & wr_ones[event_irq_pkg::OUT_ENABLE_BIT];
    wire [15:0] src_clear = enable_write ? (wr_ones & event_irq_pkg::SOURCE_MASK)
                                         : 16'h0000;
    wire [15:0] all_clear = out_disable_wr ? event_irq_pkg::SOURCE_MASK : 16'h0000;
    wire [15:0] flag_clear = flag_write ? (wr_ones & event_irq_pkg::FLAG_WRITABLE)
                                        : 16'h0000;
    wire [15:0] set_one = src_clear | all_clear | flag_clear;

    // set wins over clear: an event in the clearing cycle still lands
    // reserved flag bits are forced to one on every edge
    assign next_flags = ((flag_reg | set_one) & ~event_low)
                        | ~event_irq_pkg::FLAG_WRITABLE;

    // reserved enable bits are fixed at one
    wire [15:0] enable_merged = merge16(enable_reg, req.writedata, req.byteenable);
    assign next_enable = enable_write ? (enable_merged | ~event_irq_pkg::ENABLE_WRITABLE)
                                      : enable_reg;

    // pending excludes the power-on flag entirely
    wire [15:0] pending_vec = ~flag_reg & ~enable_reg & event_irq_pkg::SOURCE_MASK;
    wire pending = |pending_vec;
    assign next_alert_oe = ~enable_reg[event_irq_pkg::OUT_ENABLE_BIT] & pending;

    // read mux; narrow registers sit in the low half
    wire [31:0] read_mux = hit_enable ? {16'h0000, enable_reg} :
                           hit_flag ? {16'h0000, flag_reg} : 32'h00000000;

    // enable register
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            enable_reg <= event_irq_pkg::ENABLE_RESET;
        else if (!hw_reset_b)
            enable_reg <= event_irq_pkg::ENABLE_RESET;
        else
            enable_reg <= next_enable;
    end

    // flag register, active low
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            flag_reg <= event_irq_pkg::FLAG_POR_RESET;
        else if (!hw_reset_b)
            flag_reg <= event_irq_pkg::FLAG_HW_RESET;
        else
            flag_reg <= next_flags;
    end

    // alert pin: only ever pulls low, released means high impedance
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            alert_oe <= 1'b0;
            alert_out <= 1'b0;
        end
        else
        begin
            alert_oe <= hw_reset_b & next_alert_oe;
            alert_out <= 1'b0;
        end
    end

    // read data captured one cycle early; holds through the accept edge
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            readdata <= 32'h00000000;
        else if (capture && req.read)
            readdata <= read_mux;
    end

    // helpers for the checks
    wire flag_por_wr = flag_write & wr_ones[event_irq_pkg::POR_BIT];
    wire quiet = hw_reset_b & ~enable_write & ~flag_write;
    wire por_cause = ~hw_reset_b | flag_por_wr;
    wire out_enabled = ~enable_reg[event_irq_pkg::OUT_ENABLE_BIT];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_source_armed(int b);
        !enable_reg[b] && flag_reg[b] && hw_reset_b;
    endsequence

    sequence s_pin_armed;
        !enable_reg[event_irq_pkg::OUT_ENABLE_BIT] && hw_reset_b && !enable_write;
    endsequence

    chk_pin_low_only: assert property (alert_out == 1'b0)
        else $error("alert pin driven high");

    chk_output_gate: assert property (
        enable_reg[event_irq_pkg::OUT_ENABLE_BIT] |=> !alert_oe)
        else $error("alert driven while output disabled");

    chk_disable_clears: assert property ((out_disable_wr && hw_reset_b && event_low == 16'h0000)
        |=> ((flag_reg & event_irq_pkg::SOURCE_MASK) == event_irq_pkg::SOURCE_MASK))
        else $error("output disable did not clear flags");

    chk_ready_latch: assert property ((s_source_armed(event_irq_pkg::READY_BIT) and
        s_pin_armed) ##0 events.ready ##1 quiet |=> alert_oe)
        else $error("ready event did not raise alert");

    chk_ecc2_latch: assert property (s_source_armed(event_irq_pkg::ECC2_BIT) ##0 events.ecc2
        |=> !flag_reg[event_irq_pkg::ECC2_BIT])
        else $error("two-bit ECC event not latched");

    chk_ecc1_latch: assert property (s_source_armed(event_irq_pkg::ECC1_BIT) ##0 events.ecc1
        |=> !flag_reg[event_irq_pkg::ECC1_BIT])
        else $error("one-bit ECC event not latched");

    chk_src_clear: assert property ((src_clear[event_irq_pkg::ECC1_BIT] && !event_low[0]
        && hw_reset_b) |=> flag_reg[event_irq_pkg::ECC1_BIT])
        else $error("disabling a source left its flag low");

    chk_alert_release: assert property ((!pending || !hw_reset_b) |=> !alert_oe)
        else $error("alert held with nothing pending");

    chk_masked_ignore: assert property ((enable_reg[event_irq_pkg::ECC1_BIT] &&
        flag_reg[event_irq_pkg::ECC1_BIT]) |=> flag_reg[event_irq_pkg::ECC1_BIT])
        else $error("disabled source latched a flag");

    chk_hw_reset: assert property (!hw_reset_b |=> (enable_reg == event_irq_pkg::ENABLE_RESET
        && flag_reg == event_irq_pkg::FLAG_HW_RESET && !alert_oe))
        else $error("hardware reset values wrong");

    chk_por_flag_set: assert property ($rose(flag_reg[event_irq_pkg::POR_BIT])
        |-> $past(por_cause))
        else $error("power-on flag set without cause");

    chk_por_no_effect: assert property (($changed(flag_reg[event_irq_pkg::POR_BIT]) &&
        $stable(pending_vec) && $stable(enable_reg) && hw_reset_b && $past(hw_reset_b))
        |=> $stable(alert_oe))
        else $error("power-on flag moved the alert pin");

    chk_fall_needs_event: assert property ($fell(flag_reg[event_irq_pkg::READY_BIT])
        |-> $past(events.ready))
        else $error("ready flag fell without an event");

    // the other two sources may only fall through their own pulse
    chk_ecc2_fall: assert property (
        $fell(flag_reg[event_irq_pkg::ECC2_BIT]) |-> $past(events.ecc2))
        else $error("two-bit ECC flag fell without an event");

    chk_ecc1_fall: assert property (
        $fell(flag_reg[event_irq_pkg::ECC1_BIT]) |-> $past(events.ecc1))
        else $error("one-bit ECC flag fell without an event");

    // reserved bits read as one whatever software writes
    chk_flag_reserved: assert property (
        (flag_reg | event_irq_pkg::FLAG_WRITABLE) == 16'hFFFF)
        else $error("reserved flag bit cleared");

    chk_enable_reserved: assert property (
        (enable_reg | event_irq_pkg::ENABLE_WRITABLE) == 16'hFFFF)
        else $error("reserved enable bit cleared");

    // masked sources keep their flags idle
    chk_ecc2_masked: assert property (
        (enable_reg[event_irq_pkg::ECC2_BIT] && flag_reg[event_irq_pkg::ECC2_BIT])
        |=> flag_reg[event_irq_pkg::ECC2_BIT])
        else $error("disabled two-bit source latched a flag");

    chk_ready_masked: assert property (
        (enable_reg[event_irq_pkg::READY_BIT] && flag_reg[event_irq_pkg::READY_BIT])
        |=> flag_reg[event_irq_pkg::READY_BIT])
        else $error("disabled ready source latched a flag");

    // an armed ready pulse lands in its flag on the next edge
    chk_ready_flag: assert property (
        s_source_armed(event_irq_pkg::READY_BIT) ##0 events.ready
        |=> !flag_reg[event_irq_pkg::READY_BIT])
        else $error("ready event not latched");

    // disabling a source also returns its flag, unless an event collides
    chk_ecc2_src_clear: assert property (
        (src_clear[event_irq_pkg::ECC2_BIT] && !event_low[event_irq_pkg::ECC2_BIT]
        && hw_reset_b) |=> flag_reg[event_irq_pkg::ECC2_BIT])
        else $error("disabling two-bit source left its flag low");

    chk_ready_src_clear: assert property (
        (src_clear[event_irq_pkg::READY_BIT] && !event_low[event_irq_pkg::READY_BIT]
        && hw_reset_b) |=> flag_reg[event_irq_pkg::READY_BIT])
        else $error("disabling ready source left its flag low");

    // a one written to the flag register returns that flag
    chk_flag_write_ecc1: assert property (
        (flag_write && wr_ones[event_irq_pkg::ECC1_BIT] && !event_low[event_irq_pkg::ECC1_BIT]
        && hw_reset_b) |=> flag_reg[event_irq_pkg::ECC1_BIT])
        else $error("flag write left one-bit flag low");

    chk_flag_write_ecc2: assert property (
        (flag_write && wr_ones[event_irq_pkg::ECC2_BIT] && !event_low[event_irq_pkg::ECC2_BIT]
        && hw_reset_b) |=> flag_reg[event_irq_pkg::ECC2_BIT])
        else $error("flag write left two-bit flag low");

    // once set, the power-on flag stays set until the next power-on
    chk_por_no_fall: assert property (
        flag_reg[event_irq_pkg::POR_BIT] |=> flag_reg[event_irq_pkg::POR_BIT])
        else $error("power-on flag cleared outside power-on");

    chk_por_write_sets: assert property (
        (flag_por_wr && hw_reset_b) |=> flag_reg[event_irq_pkg::POR_BIT])
        else $error("flag write did not set power-on flag");

    // the pin only pulls while something was pending and the gate was open
    chk_alert_cause: assert property (
        alert_oe |-> $past(pending))
        else $error("alert driven with nothing pending");

    chk_alert_gate: assert property (
        alert_oe |-> $past(out_enabled))
        else $error("alert driven through a closed gate");

    // enables move only through a write or a hardware reset
    chk_enable_hold: assert property (
        (!enable_write && hw_reset_b) |=> $stable(enable_reg))
        else $error("enable register changed without a write");

    // each ECC source raises the pin on its own
    chk_ecc1_alert: assert property (
        (s_source_armed(event_irq_pkg::ECC1_BIT) and s_pin_armed) ##0 events.ecc1
        ##1 quiet |=> alert_oe)
        else $error("one-bit ECC event did not raise alert");

    chk_ecc2_alert: assert property (
        (s_source_armed(event_irq_pkg::ECC2_BIT) and s_pin_armed) ##0 events.ecc2
        ##1 quiet |=> alert_oe)
        else $error("two-bit ECC event did not raise alert");

    // a ready pulse is one cycle long, so one busy fall counts once
    chk_ready_once: assert property (
        events.ready |=> !events.ready)
        else $error("ready pulse longer than one cycle");

    // read data mirror the register as it stood in the capture cycle
    chk_read_flag: assert property (
        (capture && req.read && hit_flag) |=> readdata == {16'h0000, $past(flag_reg)})
        else $error("flag read returned wrong data");

    chk_read_enable: assert property (
        (capture && req.read && hit_enable) |=> readdata == {16'h0000, $past(enable_reg)})
        else $error("enable read returned wrong data");

    chk_read_unmapped: assert property (
        (capture && req.read && !hit_enable && !hit_flag) |=> readdata == 32'h00000000)
        else $error("unmapped read returned data");
endmodule
`default_nettype wire

// ### dv/host_alert_input.sv
`default_nettype none
module host_alert_input (
    input wire logic alert_out, // pin drive value
    input wire logic alert_oe, // pin drive enable
    output logic irq_level // level seen by the host
);
    timeunit 1ns;
    timeprecision 1ns;
    // the board pull-up wins whenever the device lets go of the pin
    assign irq_level = alert_oe ? alert_out : 1'b1;
endmodule
`default_nettype wire

// ### dv/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic hw_reset_b = 1'b1;
    logic busy = 1'b0;
    logic ecc1_detect = 1'b0;
    logic ecc2_detect = 1'b0;
    logic [event_irq_pkg::BUS_ADDR_W-1:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h00000000;
    logic [31:0] readdata;
    logic waitrequest;
    logic alert_out;
    logic alert_oe;
    logic irq_level;
    logic [31:0] rd;
    int srcs[3] = '{0, 1, 4};
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;

    flash_event_interrupt_logic i_dut (.clk(clk), .rst_b(rst_b), .hw_reset_b(hw_reset_b),
        .busy(busy), .ecc1_detect(ecc1_detect), .ecc2_detect(ecc2_detect),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
        .alert_out(alert_out), .alert_oe(alert_oe));
    host_alert_input i_host (.alert_out(alert_out), .alert_oe(alert_oe),
        .irq_level(irq_level));

    always #25 clk = ~clk;

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // a hung handshake ends here instead of running forever
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            print_verdict();
        end
    end

    task automatic check_reg(input string name, input logic [15:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== {16'h0000, exp})
            $display("wrong value %s expected %h seen %h", name, {16'h0000, exp}, got);
        if (got !== {16'h0000, exp})
            num_errors++;
    endtask

    task automatic check_pin(input logic exp);
        num_checks++;
        if (irq_level !== exp)
            $display("wrong value alert expected %b seen %b", exp, irq_level);
        if (irq_level !== exp)
            num_errors++;
    endtask

    // request held until the edge that samples waitrequest low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        read <= ~wr;
        write <= wr;
        address <= a;
        writedata <= {16'h0000, d};
        @(posedge clk);
        while (waitrequest !== 1'b0)
            @(posedge clk);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // one-cycle event; index 4 is a busy pulse whose fall means ready
    task automatic fire(input int src);
        @(posedge clk);
        ecc1_detect <= (src == 0);
        ecc2_detect <= (src == 1);
        busy <= (src == 4);
        @(posedge clk);
        ecc1_detect <= 1'b0;
        ecc2_detect <= 1'b0;
        busy <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    initial
    begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        bus(0, 4'h0, 16'h0000);
        check_reg("enable", 16'hFFFF, rd);
        bus(0, 4'h4, 16'h0000);
        check_reg("flag", 16'hFFFB, rd);
        check_pin(1'b1);
        bus(1, 4'h0, 16'h7FEC);
        bus(0, 4'h0, 16'h0000);
        check_reg("enable", 16'h7FEC, rd);
        check_pin(1'b1);
        // each source alone: latch, alert, then disable it
        foreach (srcs[i])
        begin
            bus(1, 4'h0, 16'h7FFF & ~(16'h0001 << srcs[i]));
            fire(srcs[i]);
            check_pin(1'b0);
            bus(0, 4'h4, 16'h0000);
            check_reg("flag", 16'hFFFB & ~(16'h0001 << srcs[i]), rd);
            bus(1, 4'h0, 16'h7FFF);
            bus(0, 4'h4, 16'h0000);
            check_reg("flag", 16'hFFFB, rd);
            check_pin(1'b1);
        end
        // disabled sources leave no trace
        bus(1, 4'h0, 16'h7FFE);
        fire(1);
        fire(4);
        bus(0, 4'h4, 16'h0000);
        check_reg("flag", 16'hFFFB, rd);
        check_pin(1'b1);
        // two pending flags: pin holds until both are cleared
        bus(1, 4'h0, 16'h7FFC);
        fire(0);
        fire(1);
        bus(1, 4'h4, 16'h0001);
        check_pin(1'b0);
        bus(0, 4'h4, 16'h0000);
        check_reg("flag", 16'hFFF9, rd);
        bus(1, 4'h4, 16'h0002);
        check_pin(1'b1);
        // output gate: latched but silent, then released by bit 15
        bus(1, 4'h0, 16'hFFFD);
        fire(1);
        check_pin(1'b1);
        bus(1, 4'h0, 16'h7FFD);
        check_pin(1'b0);
        bus(1, 4'h0, 16'hFFFD);
        check_pin(1'b1);
        bus(0, 4'h4, 16'h0000);
        check_reg("flag", 16'hFFFB, rd);
        // unmapped place: write ignored, read zero
        bus(1, 4'h8, 16'h0000);
        bus(0, 4'h0, 16'h0000);
        check_reg("enable", 16'hFFFD, rd);
        bus(0, 4'h8, 16'h0000);
        check_reg("unmapped", 16'h0000, rd);
        // hardware reset with an alert pending
        bus(1, 4'h0, 16'h7FFE);
        fire(0);
        check_pin(1'b0);
        hw_reset_b <= 1'b0;
        @(posedge clk);
        hw_reset_b <= 1'b1;
        repeat (2) @(posedge clk);
        check_pin(1'b1);
        bus(0, 4'h0, 16'h0000);
        check_reg("enable", 16'hFFFF, rd);
        bus(0, 4'h4, 16'h0000);
        check_reg("flag", 16'hFFFF, rd);
        // second power-on, then the flag write sets the power-on bit
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        bus(0, 4'h4, 16'h0000);
        check_reg("flag", 16'hFFFB, rd);
        bus(1, 4'h4, 16'h0004);
        bus(0, 4'h4, 16'h0000);
        check_reg("flag", 16'hFFFF, rd);
        print_verdict();
    end
endmodule
`default_nettype wire
